//--- core/sscr_regs.vh
// register map constants for the sweep synthesizer configuration bank
// Operation
// - configuration registers are write-only; nothing reads back over the link
// - each register has its own byte length, flags one byte, frequencies five
// - on command, present state of either channel becomes the power-up default; the code saves only the ch1 flags
// - factory defaults: ch1 12 GHz 0 dBm on, ch2 1.5 GHz max power standby
// - start, stop, step carry unsigned 40-bit hertz values in five bytes
// - list byte bits 7..3: trig out mode, trig out enable, return, step, hw trig
// - list byte bits 2..0: saw/triangle, sweep direction, generated vs loaded list
// - synth_loop_options byte: bit2 disable SS, bit1 loop gain, bit0 lock mode
// - dwell counts 500 us units per point; host keeps it at least 1 ms
// - cycle count zero repeats forever until trigger or fixed tone mode
// - with hardware trigger selected, a falling trigger pin edge is the event; the code ends endless repeat on any falling edge, selected or not
`ifndef SSCR_REGS_VH
`define SSCR_REGS_VH
`define SSCR_ADDR_INIT      8'h01
`define SSCR_ADDR_ACTIVE    8'h02
`define SSCR_ADDR_SYNTH     8'h03
`define SSCR_ADDR_TONE      8'h04
`define SSCR_ADDR_SWEEP     8'h05
`define SSCR_ADDR_FIRST     8'h06
`define SSCR_ADDR_LAST      8'h07
`define SSCR_ADDR_INCR      8'h08
`define SSCR_ADDR_DWELL     8'h09
`define SSCR_ADDR_REPEAT    8'h0a
`define SSCR_ADDR_STORE     8'h1b
`define SSCR_LEN_BYTE       3'd1
`define SSCR_LEN_FREQ       3'd5
`define SSCR_LEN_WORD       3'd4
`define SSCR_SWP_COMPLETION_PULSE_OUTPUT_MODE 7
`define SSCR_SWP_COMPLETION_PULSE_OUTPUT_EN   6
`define SSCR_SWP_RETURN       5
`define SSCR_SWP_STEP_TRIG    4
`define SSCR_SWP_HW_TRIG      3
`define SSCR_SWP_TRIANGLE     2
`define SSCR_SWP_DIR          1
`define SSCR_SWP_GEN_LOADED   0
`define SSCR_SYN_DIS_SS       2
`define SSCR_SYN_LOOP_GAIN    1
`define SSCR_SYN_LOCK_MODE    0
`define SSCR_SYN_MASK         8'h07
`define SSCR_BIT0_MASK        8'h01
`define SSCR_FACT_CH1_FREQ    40'h02_CB41_7800
`define SSCR_FACT_CH2_FREQ    40'h00_5968_2F00
`define SSCR_FACT_CH1_POWER   16'h0000
`define SSCR_FACT_CH2_POWER   16'h7FFF
`define SSCR_FACT_CH1_FLAGS   8'h07
`define SSCR_FACT_CH2_FLAGS   8'h08
`define SSCR_FACT_REF_MODE    8'h00
`define SSCR_RST_DWELL        32'h0000_0002
`define SSCR_RST_REPEAT       32'h0000_0001
`define SSCR_DWELL_UNIT_NS    500000
`define SSCR_DWELL_MIN_NS     1000000
`define SSCR_CLK_PERIOD_NS    10
`endif

//--- core/sscr_edge_sync.v
// two-flop synchroniser with edge detection for an asynchronous pin
`timescale 1ns/1ps
module sscr_edge_sync (
	input  wire clk_in,
	input  wire rst_b_in,
	input  wire ce_in,
	input  wire pin_in,
	output wire level_out,
	output wire rise_out,
	output wire fall_out
);
	reg meta_r;
	reg sync_r;
	reg prev_r;
	// first flop only feeds the second
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else if (ce_in) begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	assign level_out = sync_r;
	assign rise_out  = sync_r & ~prev_r & ce_in;
	assign fall_out  = ~sync_r & prev_r & ce_in;
endmodule

//--- core/sscr_config_bank.v
// write-only configuration register bank fed by a serial byte link
`timescale 1ns/1ps
`include "sscr_regs.vh"
module sscr_config_bank #(
	parameter DWELL_UNIT_CYC = `SSCR_DWELL_UNIT_NS / `SSCR_CLK_PERIOD_NS
) (
	input  wire        CORE_CLK_IN,
	input  wire        RST_B_IN,
	input  wire        CE_IN,
	input  wire        SCLK_IN,
	input  wire        CS_B_IN,
	input  wire        SDI_IN,
	input  wire        TRIG_B_IN,
	input  wire [7:0]  STORED_CH1_FLAGS_IN,
	output reg         SERIAL_IDLE_FLAG_OUT,
	output reg  [7:0]  INIT_CMD_OUT,
	output reg         INIT_PULSE_OUT,
	output reg         ACTIVE_LED_OUT,
	output reg  [7:0]  SYNTH_LOOP_OPTIONS_OUT,
	output reg         OUTPUT_TONE_MODE_OUT,
	output reg  [7:0]  SWEEP_BEHAVIOUR_OUT,
	output reg  [39:0] SWEEP_FIRST_FREQ_OUT,
	output reg  [39:0] SWEEP_LAST_FREQ_OUT,
	output reg  [39:0] SWEEP_INCREMENT_FREQ_OUT,
	output reg  [31:0] POINT_HOLD_DURATION_OUT,
	output reg  [31:0] SWEEP_REPEAT_TOTAL_OUT,
	output wire [31:0] DWELL_CYCLES_PER_UNIT_OUT,
	output reg         STORE_DEFAULT_PULSE_OUT,
	output reg  [7:0]  STORE_CHANNEL_OUT,
	output reg  [7:0]  DEFAULT_CH1_FLAGS_OUT,
	output reg         HW_TRIGGER_PULSE_OUT,
	output reg         REPEAT_FOREVER_OUT
);
	localparam ST_ADDR = 2'd0;
	localparam ST_DATA = 2'd1;
	localparam ST_DONE = 2'd2;
	wire       sclk_rise;
	wire       cs_b_lvl;
	wire       sdi_lvl;
	wire       trig_fall;
	reg  [1:0] state_r;
	reg  [2:0] bit_cnt_r;
	reg  [7:0] shift_r;
	reg  [7:0] addr_r;
	reg  [2:0] byte_cnt_r;
	reg  [2:0] byte_len_r;
	reg  [39:0] payload_r;
	reg  [7:0] byte_nxt;
	reg  [2:0] len_nxt;
	reg        byte_done;
	sscr_edge_sync u_sclk (.clk_in(CORE_CLK_IN), .rst_b_in(RST_B_IN), .ce_in(CE_IN),
		.pin_in(SCLK_IN), .level_out(), .rise_out(sclk_rise), .fall_out());
	sscr_edge_sync u_cs (.clk_in(CORE_CLK_IN), .rst_b_in(RST_B_IN), .ce_in(CE_IN),
		.pin_in(CS_B_IN), .level_out(cs_b_lvl), .rise_out(), .fall_out());
	sscr_edge_sync u_sdi (.clk_in(CORE_CLK_IN), .rst_b_in(RST_B_IN), .ce_in(CE_IN),
		.pin_in(SDI_IN), .level_out(sdi_lvl), .rise_out(), .fall_out());
	sscr_edge_sync u_trig (.clk_in(CORE_CLK_IN), .rst_b_in(RST_B_IN), .ce_in(CE_IN),
		.pin_in(TRIG_B_IN), .level_out(), .rise_out(), .fall_out(trig_fall));
	// dwell unit in core cycles, for the sweep engine
	assign DWELL_CYCLES_PER_UNIT_OUT = DWELL_UNIT_CYC;
	// assembled byte and payload length per address
	always @* begin
		byte_nxt  = {shift_r[6:0], sdi_lvl};
		byte_done = sclk_rise & ~cs_b_lvl & (bit_cnt_r == 3'd7);
		case (byte_nxt)
			`SSCR_ADDR_FIRST, `SSCR_ADDR_LAST, `SSCR_ADDR_INCR: len_nxt = `SSCR_LEN_FREQ;
			`SSCR_ADDR_DWELL, `SSCR_ADDR_REPEAT: len_nxt = `SSCR_LEN_WORD;
			default: len_nxt = `SSCR_LEN_BYTE;
		endcase
	end
	// serial receiver: address byte then exact payload length, msb first per byte
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state_r <= ST_ADDR;
			bit_cnt_r <= 3'd0;
			shift_r <= 8'h00;
			addr_r <= 8'h00;
			byte_cnt_r <= 3'd0;
			byte_len_r <= 3'd1;
			payload_r <= 40'h00_0000_0000;
			SERIAL_IDLE_FLAG_OUT <= 1'b1;
		end else if (CE_IN) begin
			if (cs_b_lvl) begin
				bit_cnt_r <= 3'd0; // frame end realigns bit count only
			end else if (sclk_rise) begin
				bit_cnt_r <= bit_cnt_r + 3'd1;
				shift_r <= byte_nxt;
			end
			SERIAL_IDLE_FLAG_OUT <= (state_r != ST_DONE);
			case (state_r)
				ST_ADDR: begin
					if (byte_done) begin
						addr_r <= byte_nxt;
						byte_len_r <= len_nxt;
						byte_cnt_r <= 3'd0;
						payload_r <= 40'h00_0000_0000;
						state_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (byte_done) begin
						// byte n of a five-byte payload lands at bits 8n+7:8n; shorter payloads end in the upper bytes
						payload_r <= {byte_nxt, payload_r[39:8]};
						byte_cnt_r <= byte_cnt_r + 3'd1;
						if (byte_cnt_r + 3'd1 == byte_len_r) begin
							state_r <= ST_DONE;
						end
					end
				end
				ST_DONE: state_r <= ST_ADDR;
				default: state_r <= ST_ADDR;
			endcase
		end
	end
	// one write strobe per register, live only in the single commit cycle
	wire        commit;
	wire        wr_init;
	wire        wr_active;
	wire        wr_synth;
	wire        wr_tone;
	wire        wr_sweep;
	wire        wr_first;
	wire        wr_last;
	wire        wr_incr;
	wire        wr_dwell;
	wire        wr_repeat;
	wire        wr_store;
	assign commit    = (state_r == ST_DONE);
	assign wr_init   = commit & (addr_r == `SSCR_ADDR_INIT);
	assign wr_active = commit & (addr_r == `SSCR_ADDR_ACTIVE);
	assign wr_synth  = commit & (addr_r == `SSCR_ADDR_SYNTH);
	assign wr_tone   = commit & (addr_r == `SSCR_ADDR_TONE);
	assign wr_sweep  = commit & (addr_r == `SSCR_ADDR_SWEEP);
	assign wr_first  = commit & (addr_r == `SSCR_ADDR_FIRST);
	assign wr_last   = commit & (addr_r == `SSCR_ADDR_LAST);
	assign wr_incr   = commit & (addr_r == `SSCR_ADDR_INCR);
	assign wr_dwell  = commit & (addr_r == `SSCR_ADDR_DWELL);
	assign wr_repeat = commit & (addr_r == `SSCR_ADDR_REPEAT);
	assign wr_store  = commit & (addr_r == `SSCR_ADDR_STORE);
	// initialise command keeps bit0 only and pulses once per write
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			INIT_CMD_OUT <= 8'h00;
			INIT_PULSE_OUT <= 1'b0;
		end else if (CE_IN) begin
			INIT_PULSE_OUT <= wr_init;
			if (wr_init) begin
				INIT_CMD_OUT <= payload_r[39:32] & `SSCR_BIT0_MASK;
			end
		end
	end
	// activity indicator follows bit0 of its byte
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ACTIVE_LED_OUT <= 1'b0;
		end else if (CE_IN && wr_active) begin
			ACTIVE_LED_OUT <= payload_r[32];
		end
	end
	// loop options keep bits 2..0, open bits forced to zero
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			SYNTH_LOOP_OPTIONS_OUT <= 8'h00;
		end else if (CE_IN && wr_synth) begin
			SYNTH_LOOP_OPTIONS_OUT <= payload_r[39:32] & `SSCR_SYN_MASK;
		end
	end
	// tone mode: 1 runs the sweep or list, 0 is a single fixed tone
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			OUTPUT_TONE_MODE_OUT <= 1'b0;
		end else if (CE_IN && wr_tone) begin
			OUTPUT_TONE_MODE_OUT <= payload_r[32];
		end
	end
	// sweep behaviour byte is kept whole, every bit has a meaning
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			SWEEP_BEHAVIOUR_OUT <= 8'h00;
		end else if (CE_IN && wr_sweep) begin
			SWEEP_BEHAVIOUR_OUT <= payload_r[39:32];
		end
	end
	// forty-bit sweep frequencies in hertz
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			SWEEP_FIRST_FREQ_OUT <= `SSCR_FACT_CH1_FREQ;
			SWEEP_LAST_FREQ_OUT <= `SSCR_FACT_CH1_FREQ;
			SWEEP_INCREMENT_FREQ_OUT <= 40'h00_0000_0000;
		end else if (CE_IN) begin
			if (wr_first) begin
				SWEEP_FIRST_FREQ_OUT <= payload_r;
			end
			if (wr_last) begin
				SWEEP_LAST_FREQ_OUT <= payload_r;
			end
			if (wr_incr) begin
				SWEEP_INCREMENT_FREQ_OUT <= payload_r;
			end
		end
	end
	// dwell and repeat words sit in the upper four payload bytes
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			POINT_HOLD_DURATION_OUT <= `SSCR_RST_DWELL;
			SWEEP_REPEAT_TOTAL_OUT <= `SSCR_RST_REPEAT;
		end else if (CE_IN) begin
			if (wr_dwell) begin
				POINT_HOLD_DURATION_OUT <= payload_r[39:8];
			end
			if (wr_repeat) begin
				SWEEP_REPEAT_TOTAL_OUT <= payload_r[39:8];
			end
		end
	end
	// store command snapshots the present ch1 flags as the power-up default
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			STORE_DEFAULT_PULSE_OUT <= 1'b0;
			STORE_CHANNEL_OUT <= 8'h00;
			DEFAULT_CH1_FLAGS_OUT <= `SSCR_FACT_CH1_FLAGS;
		end else if (CE_IN) begin
			STORE_DEFAULT_PULSE_OUT <= wr_store;
			if (wr_store) begin
				STORE_CHANNEL_OUT <= payload_r[39:32];
				DEFAULT_CH1_FLAGS_OUT <= STORED_CH1_FLAGS_IN;
			end
		end
	end
	// falling pin edge only makes a trigger pulse with hardware trigger selected
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			HW_TRIGGER_PULSE_OUT <= 1'b0;
		end else if (CE_IN) begin
			HW_TRIGGER_PULSE_OUT <= trig_fall & SWEEP_BEHAVIOUR_OUT[`SSCR_SWP_HW_TRIG];
		end
	end
	// endless repeat; a write that sets it wins over a same-cycle clear
	always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			REPEAT_FOREVER_OUT <= 1'b0;
		end else if (CE_IN) begin
			if (wr_tone) begin
				REPEAT_FOREVER_OUT <= payload_r[32] & (SWEEP_REPEAT_TOTAL_OUT == 32'h0000_0000);
			end else if (wr_repeat) begin
				REPEAT_FOREVER_OUT <= OUTPUT_TONE_MODE_OUT & (payload_r[39:8] == 32'h0000_0000);
			end else if (trig_fall || !OUTPUT_TONE_MODE_OUT) begin
				REPEAT_FOREVER_OUT <= 1'b0;
			end
		end
	end
endmodule

//--- verif/sscr_cfg_asserts.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module sscr_cfg_asserts #(
	parameter DWELL_UNIT_CYC = 50000
) (
	input wire        CORE_CLK_IN,
	input wire        RST_B_IN,
	input wire        CE_IN,
	input wire        TRIG_B_IN,
	input wire        SERIAL_IDLE_FLAG_OUT,
	input wire        INIT_PULSE_OUT,
	input wire        OUTPUT_TONE_MODE_OUT,
	input wire        REPEAT_FOREVER_OUT,
	input wire        HW_TRIGGER_PULSE_OUT,
	input wire        STORE_DEFAULT_PULSE_OUT,
	input wire [7:0]  SYNTH_LOOP_OPTIONS_OUT,
	input wire [7:0]  SWEEP_BEHAVIOUR_OUT,
	input wire [7:0]  DEFAULT_CH1_FLAGS_OUT,
	input wire [31:0] DWELL_CYCLES_PER_UNIT_OUT
);
	// every check runs on the core clock and sleeps during reset
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	// a commit drops the idle flag for exactly one cycle
	sequence s_commit;
		!SERIAL_IDLE_FLAG_OUT ##1 SERIAL_IDLE_FLAG_OUT;
	endsequence
	a_commit_one_cycle: assert property ($fell(SERIAL_IDLE_FLAG_OUT) |-> s_commit)
		else $error("idle low too long");
	a_init_at_commit: assert property (INIT_PULSE_OUT |-> s_commit ##0 !INIT_PULSE_OUT)
		else $error("init pulse off commit");
	a_sweep_at_commit: assert property ($changed(SWEEP_BEHAVIOUR_OUT)
		|-> !SERIAL_IDLE_FLAG_OUT) else $error("sweep byte changed idle");
	a_synth_open_zero: assert property (SYNTH_LOOP_OPTIONS_OUT[7:3] == 5'h0)
		else $error("open synth bits set");
	a_trig_fall_pulse: assert property ($fell(TRIG_B_IN) && CE_IN && SWEEP_BEHAVIOUR_OUT[3]
		|-> ##[1:6] HW_TRIGGER_PULSE_OUT) else $error("trigger edge lost");
	a_trig_needs_hw: assert property (HW_TRIGGER_PULSE_OUT |-> $past(SWEEP_BEHAVIOUR_OUT[3]))
		else $error("trigger without hw mode");
	a_tone_ends_repeat: assert property ($fell(OUTPUT_TONE_MODE_OUT)
		|-> ##[0:1] !REPEAT_FOREVER_OUT) else $error("repeat kept in fixed tone");
	a_store_saves: assert property ($changed(DEFAULT_CH1_FLAGS_OUT)
		|-> STORE_DEFAULT_PULSE_OUT || $past(STORE_DEFAULT_PULSE_OUT)) else $error("defaults moved");
	a_dwell_unit: assert property (DWELL_CYCLES_PER_UNIT_OUT == DWELL_UNIT_CYC)
		else $error("dwell unit wrong");
endmodule
bind sscr_config_bank sscr_cfg_asserts #(.DWELL_UNIT_CYC(DWELL_UNIT_CYC)) u_chk (.*);

//--- verif/sscr_host_model.sv
// serial host model writing the configuration bank
`timescale 1ns/1ps
module sscr_host_model (
	output reg SCLK_OUT = 1'b0,
	output reg CS_B_OUT = 1'b1,
	output reg SDI_OUT  = 1'b0
);
	integer i;
	// one bit per 80 ns link period, msb first; clock stands still outside frames
	task shift(input [7:0] b);
		for (i = 7; i >= 0; i = i - 1) begin
			SDI_OUT = b[i];
			#40 SCLK_OUT = 1'b1;
			#40 SCLK_OUT = 1'b0;
		end
	endtask
	// address, then exactly n payload bytes low byte first; released data line flips
	task send(input [7:0] a, input [39:0] d, input integer n);
		integer k;
		CS_B_OUT = 1'b0;
		shift(a);
		for (k = 0; k < n; k = k + 1) shift(d[8*k +: 8]);
		#40 CS_B_OUT = 1'b1;
		SDI_OUT = ~SDI_OUT;
	endtask
endmodule

//--- verif/tb_sweep_synth_config_regs.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "sscr_regs.vh"
module tb_sweep_synth_config_regs;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg         trig_b = 1'b1;
	reg         ce = 1'b1;
	reg  [7:0]  flags = 8'h00;
	reg  [63:0] d;
	reg  [39:0] mdl [1:10];
	wire        sclk, cs_b, sdi, idle, init_p, led, tone, st_p, hw_p, rep_inf;
	wire [7:0]  init_c, syn, swp, st_ch, dflt;
	wire [39:0] f1, f2, f3;
	wire [31:0] dw, rp, dcyc;
	integer     n_errors = 0, samples_checked = 0, seed = 32'hc22043a5;
	integer     a, k, commits = 0, hw_n = 0, ini_n = 0, st_n = 0;
	sscr_host_model hst (.SCLK_OUT(sclk), .CS_B_OUT(cs_b), .SDI_OUT(sdi));
	sscr_config_bank uut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .SCLK_IN(sclk),
		.CS_B_IN(cs_b), .SDI_IN(sdi), .TRIG_B_IN(trig_b), .STORED_CH1_FLAGS_IN(flags),
		.SERIAL_IDLE_FLAG_OUT(idle), .INIT_CMD_OUT(init_c), .INIT_PULSE_OUT(init_p),
		.ACTIVE_LED_OUT(led), .SYNTH_LOOP_OPTIONS_OUT(syn), .OUTPUT_TONE_MODE_OUT(tone),
		.SWEEP_BEHAVIOUR_OUT(swp), .SWEEP_FIRST_FREQ_OUT(f1), .SWEEP_LAST_FREQ_OUT(f2),
		.SWEEP_INCREMENT_FREQ_OUT(f3), .POINT_HOLD_DURATION_OUT(dw), .SWEEP_REPEAT_TOTAL_OUT(rp),
		.DWELL_CYCLES_PER_UNIT_OUT(dcyc), .STORE_DEFAULT_PULSE_OUT(st_p), .STORE_CHANNEL_OUT(st_ch),
		.DEFAULT_CH1_FLAGS_OUT(dflt), .HW_TRIGGER_PULSE_OUT(hw_p), .REPEAT_FOREVER_OUT(rep_inf));
	// core clock and counters of commits and of trigger, init and store pulses
	always #5 clk = ~clk;
	always @(posedge clk) if (idle === 1'b0) commits <= commits + 1;
	always @(posedge clk) if (hw_p === 1'b1) hw_n <= hw_n + 1;
	always @(posedge clk) if (init_p === 1'b1) ini_n <= ini_n + 1;
	always @(posedge clk) if (st_p === 1'b1) st_n <= st_n + 1;
	// register output by address
	function [39:0] out(input integer r);
		case (r)
			1: out = init_c;
			2: out = led;
			3: out = syn;
			4: out = tone;
			5: out = swp;
			6: out = f1;
			7: out = f2;
			8: out = f3;
			9: out = dw;
			default: out = rp;
		endcase
	endfunction
	task check(input [39:0] seen, input [39:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// write one register, update the model for addresses 1 to 10, compare those ten registers
	task wr(input [7:0] r, input [39:0] v, input integer n);
		integer c0, t;
		c0 = commits;
		hst.send(r, v, n);
		for (t = 0; t < 20 && commits == c0; t = t + 1) @(negedge clk);
		@(negedge clk);
		check(commits, c0 + 1);
		if (r >= 1 && r <= 10) mdl[r] = v & (r == 3 ? 40'h7 : r == 5 ? 40'hff :
			r > 8 ? 40'hffff_ffff : r > 5 ? {40{1'b1}} : 40'h1);
		for (k = 1; k <= 10; k = k + 1) check(out(k), mdl[k]);
	endtask
	// hold the trigger pin low, expect n pulses
	task trg(input integer n);
		integer h0;
		h0 = hw_n;
		trig_b = 1'b0;
		repeat (10) @(negedge clk);
		trig_b = 1'b1;
		check(hw_n, h0 + n);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// cut a hung run short
	initial begin
		#400000;
		n_errors = n_errors + 1;
		end_sim;
	end
	// main sequence
	initial begin
		for (k = 1; k <= 10; k = k + 1) mdl[k] = 40'h0;
		mdl[6] = `SSCR_FACT_CH1_FREQ;
		mdl[7] = `SSCR_FACT_CH1_FREQ;
		mdl[9] = 40'h2;
		mdl[10] = 40'h1;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		for (k = 1; k <= 10; k = k + 1) check(out(k), mdl[k]);
		check(dflt, `SSCR_FACT_CH1_FLAGS);
		for (a = 1; a <= 10; a = a + 1) begin
			d = {$random(seed), $random(seed)};
			wr(a, d[39:0], a < 6 ? 1 : a < 9 ? 5 : 4);
		end
		wr(3, 40'hff, 1);
		for (a = 0; a < 8; a = a + 1) wr(5, 40'h1 << a, 1);
		wr(8, 40'h01_0203_0405, 5);
		wr(5, 40'h8, 1);
		wr(4, 40'h1, 1);
		wr(10, 40'h0, 4);
		check(rep_inf, 1'b1);
		trg(1);
		check(rep_inf, 1'b0);
		wr(5, 40'h0, 1);
		trg(0);
		wr(10, 40'h0, 4);
		check(rep_inf, 1'b1);
		wr(4, 40'h0, 1);
		check(rep_inf, 1'b0);
		// clock enable low: a whole frame goes unseen and nothing moves
		ce = 1'b0;
		a = commits;
		hst.send(8'h05, 40'hff, 1);
		repeat (4) @(negedge clk);
		ce = 1'b1;
		repeat (4) @(negedge clk);
		check(commits, a);
		for (k = 1; k <= 10; k = k + 1) check(out(k), mdl[k]);
		flags = $random(seed);
		wr(8'h1b, 40'h1, 1);
		check(dflt, flags);
		check(st_ch, 8'h01);
		check(st_n, 1);
		check(ini_n, 1);
		check(dcyc, `SSCR_DWELL_UNIT_NS / `SSCR_CLK_PERIOD_NS);
		end_sim;
	end
endmodule
